// ===== design/tcr_consts.svh
// constants for the trusted-module cycle router
`ifndef TCR_CONSTS_SVH
`define TCR_CONSTS_SVH
`define TCR_ADDR_W 40
`define TCR_LEN_W 8
`define TCR_DATA_W 64
`define TCR_TAG_W 8
`define TCR_PAGE_SHIFT 12
`define TCR_LOC0_PAGE 28'hfed40
`endif

// ===== design/tcr_pkg.sv
// types for the trusted-module cycle router
package tcr_pkg;
  typedef enum logic [1:0] {
    TCR_CYC_MEM = 2'h0,
    TCR_CYC_TRUSTED = 2'h1
  } tcr_cyc_t;
  typedef enum logic [2:0] {
    TCR_ST_IDLE = 3'h1,
    TCR_ST_SEND = 3'h2,
    TCR_ST_ABORT = 3'h4
  } tcr_state_t;
endpackage

// ===== design/tcr_router.sv
// request router from host processor bus and other requesters to the south bridge link
// Contract
// - processor memory cycles hitting locality 0 page go out as trusted cycles
// - accesses outside the locality 0 page go out as ordinary memory cycles
// - locked accesses to the window are master aborted, never converted
// - non-processor requesters to the window go out as ordinary accesses
// - zero-length processor reads and writes to the window pass as trusted zero length
// - no length limit or alignment check; length and address copied unchanged
// - zero-length reads not completed internally; unaligned accesses never split
// - only locality 0 is opened for trusted conversion
//
// operation in brief:
// - one request is taken when req_valid and req_ready are both high at an enabled edge
// - req_ready drops at the take edge and stays low until the request is finished
// - a forwarded request shows on the link at the take edge itself, as req_ready drops
// - the link copy stands unchanged until the hub answers with link_ready
// - a locked window access never reaches the link; abort_valid pulses for one cycle
// - after an abort, req_ready returns at the edge where the abort pulse ends
// - after a link accept, req_ready returns at the edge where link_valid drops
//
// hazards and limits:
// - only one request is ever outstanding; throughput is one per two cycles at best
// - the hub completion path is not seen here; the hub owns converting or completing
// - a locked access outside the window is plain memory traffic, not our concern
// - a locked window access from a non-processor requester is also aborted
// - clk_en low freezes every register, including a pending abort pulse
// - link_ready is only looked at while a link cycle is pending
`timescale 1ns/10ps
`include "tcr_consts.svh"
module tcr_router #(
  parameter int ADDR_W = `TCR_ADDR_W,
  parameter int LEN_W = `TCR_LEN_W,
  parameter int DATA_W = `TCR_DATA_W,
  parameter int TAG_W = `TCR_TAG_W
) (
  // clock, reset and enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // request in
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_from_cpu,
  input wire logic req_lock,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [LEN_W-1:0] req_len,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic [TAG_W-1:0] req_tag,
  // south bridge link out
  output logic link_valid,
  input wire logic link_ready,
  output logic [1:0] link_cyc,
  output logic link_write,
  output logic [ADDR_W-1:0] link_addr,
  output logic [LEN_W-1:0] link_len,
  output logic [DATA_W-1:0] link_data,
  output logic [TAG_W-1:0] link_tag,
  // master abort report for the lock flow
  output logic abort_valid,
  output logic [TAG_W-1:0] abort_tag
);
  // width of the page number that the window compare looks at
  localparam int PAGE_W = ADDR_W - `TCR_PAGE_SHIFT;
  // base page of locality 0; wider than PAGE_W for narrow buses, so it is sliced below
  localparam logic [27:0] LOC0_PAGE = `TCR_LOC0_PAGE;

  // refuse address widths that cannot hold the window page
  if (ADDR_W < 32 || ADDR_W > 40) begin : g_bad_addr_w
    $error("tcr_router: ADDR_W must be 32 to 40");
  end
  if (LEN_W < 1 || DATA_W < 1 || TAG_W < 1) begin : g_bad_w
    $error("tcr_router: widths must be positive");
  end

  // control state: idle, link cycle pending, abort pulse
  tcr_pkg::tcr_state_t state_r, state_nxt;
  // request side flow control
  logic req_ready_r, req_ready_nxt;
  // link side copy of the taken request; all held until the hub takes it
  logic link_valid_r, link_valid_nxt;
  logic [1:0] link_cyc_r, link_cyc_nxt;
  logic link_write_r, link_write_nxt;
  logic [ADDR_W-1:0] link_addr_r, link_addr_nxt;
  logic [LEN_W-1:0] link_len_r, link_len_nxt;
  logic [DATA_W-1:0] link_data_r, link_data_nxt;
  logic [TAG_W-1:0] link_tag_r, link_tag_nxt;
  // lock flow report; the tag holds after the pulse so a slow reader can still see it
  logic abort_valid_r, abort_valid_nxt;
  logic [TAG_W-1:0] abort_tag_r, abort_tag_nxt;
  // decode helpers, combinational from the request pins
  logic win_hit;
  logic take;

  // page compare only; the low twelve bits are an offset, so any length works
  assign win_hit = (req_addr[ADDR_W-1:`TCR_PAGE_SHIFT] ==
                    LOC0_PAGE[PAGE_W-1:0]);
  assign take = req_valid && req_ready_r;

  // next-state and output computation; one request held at a time
  always_comb begin
    state_nxt = state_r;
    req_ready_nxt = req_ready_r;
    link_valid_nxt = link_valid_r;
    link_cyc_nxt = link_cyc_r;
    link_write_nxt = link_write_r;
    link_addr_nxt = link_addr_r;
    link_len_nxt = link_len_r;
    link_data_nxt = link_data_r;
    link_tag_nxt = link_tag_r;
    abort_valid_nxt = 1'b0;
    abort_tag_nxt = abort_tag_r;
    case (state_r)
      tcr_pkg::TCR_ST_IDLE: begin
        if (take) begin
          req_ready_nxt = 1'b0;
          if (req_lock && win_hit) begin
            // locked window access ends in the lock flow, nothing goes downstream
            state_nxt = tcr_pkg::TCR_ST_ABORT;
            abort_valid_nxt = 1'b1;
            abort_tag_nxt = req_tag;
          end else begin
            state_nxt = tcr_pkg::TCR_ST_SEND;
            link_valid_nxt = 1'b1;
            // trusted only for processor, non-locked, locality 0 page
            if (req_from_cpu && win_hit) begin
              link_cyc_nxt = tcr_pkg::TCR_CYC_TRUSTED;
            end else begin
              link_cyc_nxt = tcr_pkg::TCR_CYC_MEM;
            end
            // copied as-is: zero length kept, unaligned kept whole, never split
            link_write_nxt = req_write;
            link_addr_nxt = req_addr;
            link_len_nxt = req_len;
            link_data_nxt = req_data;
            link_tag_nxt = req_tag;
          end
        end
      end
      tcr_pkg::TCR_ST_SEND: begin
        // hold until the hub takes it; its completion comes back elsewhere
        if (link_ready) begin
          link_valid_nxt = 1'b0;
          req_ready_nxt = 1'b1;
          state_nxt = tcr_pkg::TCR_ST_IDLE;
        end
      end
      tcr_pkg::TCR_ST_ABORT: begin
        // the pulse ends by the default above; accept again one cycle later
        req_ready_nxt = 1'b1;
        state_nxt = tcr_pkg::TCR_ST_IDLE;
      end
      default: begin
        // an illegal code falls back to idle and drops any pending link cycle
        state_nxt = tcr_pkg::TCR_ST_IDLE;
        req_ready_nxt = 1'b1;
        link_valid_nxt = 1'b0;
      end
    endcase
  end

  // registers; clk_en low freezes everything
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= tcr_pkg::TCR_ST_IDLE;
      req_ready_r <= 1'b1;
      link_valid_r <= 1'b0;
      link_cyc_r <= 2'h0;
      link_write_r <= 1'b0;
      link_addr_r <= '0;
      link_len_r <= '0;
      link_data_r <= '0;
      link_tag_r <= '0;
      abort_valid_r <= 1'b0;
      abort_tag_r <= '0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      req_ready_r <= req_ready_nxt;
      link_valid_r <= link_valid_nxt;
      link_cyc_r <= link_cyc_nxt;
      link_write_r <= link_write_nxt;
      link_addr_r <= link_addr_nxt;
      link_len_r <= link_len_nxt;
      link_data_r <= link_data_nxt;
      link_tag_r <= link_tag_nxt;
      abort_valid_r <= abort_valid_nxt;
      abort_tag_r <= abort_tag_nxt;
    end
  end

  // every output is a plain register copy, no logic after the flops
  assign req_ready = req_ready_r;
  assign link_valid = link_valid_r;
  assign link_cyc = link_cyc_r;
  assign link_write = link_write_r;
  assign link_addr = link_addr_r;
  assign link_len = link_len_r;
  assign link_data = link_data_r;
  assign link_tag = link_tag_r;
  assign abort_valid = abort_valid_r;
  assign abort_tag = abort_tag_r;
endmodule

// ===== verif/tcr_hub_model.sv
// hub model: takes each link cycle whole after a set stall
`timescale 1ns/10ps
module tcr_hub_model (
  input logic mclk, rstn, link_valid, input logic [3:0] stall, output logic link_ready);
  logic [3:0] wait_r;
  // any length or alignment completes as one transfer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) {wait_r, link_ready} <= '0;
    else begin
      link_ready <= link_valid && !link_ready && wait_r >= stall;
      wait_r <= (link_valid && !link_ready) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

// ===== verif/tcr_router_checker.sv
// port assertions for the trusted-module cycle router
`timescale 1ns/10ps
module tcr_router_checker #(parameter int ADDR_W = 40, parameter int LEN_W = 8) (
  // watched request, link and abort ports
  input logic mclk, rstn, clk_en, req_valid, req_ready, req_from_cpu, req_lock, link_valid,
  input logic link_ready, abort_valid, input logic [1:0] link_cyc,
  input logic [LEN_W-1:0] req_len, link_len, input logic [ADDR_W-1:0] req_addr, link_addr);
  // only bits above 11 decide a hit, the low twelve are page offset
  wire hit = req_addr[ADDR_W-1:12] == 28'hfed40;
  wire tk = req_valid && req_ready && clk_en;
  wire win = tk && hit && !req_lock;
  wire fwd = tk && !(hit && req_lock);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence cy(c); link_valid && link_cyc == c; endsequence
  sequence abort_pulse; abort_valid && !link_valid ##1 !abort_valid; endsequence
  AST_TRUST: assert property (win && req_from_cpu |=> cy(2'h1)) else $error("trust");
  AST_PAGE: assert property (tk && !hit |=> cy(2'h0)) else $error("page");
  AST_PEER: assert property (win && !req_from_cpu |=> cy(2'h0)) else $error("peer");
  AST_LOCK: assert property (tk && hit && req_lock |=> abort_pulse) else $error("lock");
  AST_ADDR: assert property (fwd |=> link_addr == $past(req_addr)) else $error("ad");
  AST_LEN: assert property (fwd |=> link_len == $past(req_len)) else $error("len");
  AST_HOLD: assert property (link_valid && !link_ready |=> link_valid && $stable(link_addr))
    else $error("hold");
  AST_ONCE: assert property (link_valid && link_ready && clk_en |=> !link_valid && req_ready)
    else $error("once");
endmodule

// ===== verif/test_tcr_router.sv
// self-checking bench for the trusted-module cycle router
`timescale 1ns/10ps
module test_tcr_router;
  logic mclk, rstn, req_valid, req_ready, req_from_cpu, req_lock, req_write, link_valid;
  logic link_ready, link_write, abort_valid, clk_en;
  logic [1:0] link_cyc;
  logic [3:0] stall;
  logic [7:0] req_len, link_len, req_tag, link_tag, abort_tag;
  logic [39:0] req_addr, link_addr;
  logic [63:0] req_data, link_data;
  int n_fail, compares;
  // router under test, hub model on its link side
  tcr_router tcr_router_i (.mclk, .rstn, .clk_en, .req_valid, .req_ready, .req_from_cpu,
    .req_lock, .req_write, .req_addr, .req_len, .req_data, .req_tag, .link_valid, .link_ready,
    .link_cyc, .link_write, .link_addr, .link_len, .link_data, .link_tag, .abort_valid, .abort_tag);
  tcr_hub_model tcr_hub_model_i (.mclk, .rstn, .link_valid, .stall, .link_ready);
  // 50 ns clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task end_sim;
    $display("mismatches %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] e, s);
    compares++;
    if (s !== e) n_fail++;
    if (s !== e) $display("[ERR] %s exp %h got %h", nm, e, s);
  endtask
  // one request: judged at the answer cycle, then waited out to completion
  task automatic xfer(input logic cpu, lk, w, input logic [39:0] a, input logic [7:0] n);
    int k;
    logic ab;
    logic [1:0] cy;
    ab = lk && a[39:12] == 28'hfed40;
    cy = {1'b0, cpu && !lk && a[39:12] == 28'hfed40};
    {req_valid, req_from_cpu, req_lock, req_write, req_addr, req_len} = {1'b1, cpu, lk, w, a, n};
    req_tag = req_tag + 8'h1;
    req_data = {n, 16'h0, a};
    @(negedge mclk);
    req_valid = 1'b0;
    chk("abort", ab, abort_valid);
    if (ab) begin
      chk("abort_tag", req_tag, abort_tag);
      chk("nolink", 1'b0, link_valid);
    end else begin
      chk("link", {1'b1, cy, w, a, n, req_tag},
        {link_valid, link_cyc, link_write, link_addr, link_len, link_tag});
      chk("data", {n, 16'h0, a}, link_data);
    end
    for (k = 0; k < 20 && (link_valid !== 1'b0 || req_ready !== 1'b1); k++) @(negedge mclk);
    chk("done", 1'b1, k < 20);
  endtask
  task s_route;
    xfer(1, 0, 1, 40'hfed40000, 8'h4);
    xfer(1, 0, 0, 40'hfed40ffc, 8'h4);
    xfer(1, 0, 1, 40'hfed41000, 8'h4);
    xfer(1, 0, 0, 40'hfed3fffc, 8'h4);
    xfer(0, 0, 1, 40'hfed40010, 8'h4);
    xfer(1, 1, 0, 40'hfed40020, 8'h4);
  endtask
  task s_shape;
    stall = 4'h3;
    xfer(1, 0, 0, 40'hfed40008, 8'h0);
    xfer(1, 0, 1, 40'hfed40ffe, 8'hff);
  endtask
  // a request offered while clk_en is low must not be taken
  task s_freeze;
    clk_en = 1'b0;
    {req_valid, req_from_cpu, req_lock, req_addr} = {1'b1, 1'b1, 1'b0, 40'hfed40000};
    repeat (3) @(negedge mclk);
    chk("frozen", 1'b0, link_valid);
    chk("frozen_rdy", 1'b1, req_ready);
    req_valid = 1'b0;
    clk_en = 1'b1;
    @(negedge mclk);
    xfer(1, 0, 0, 40'hfed40004, 8'h2);
  endtask
  // reset, then the scenarios
  initial begin
    {rstn, req_valid, req_from_cpu, req_lock, req_write, req_addr, req_len, req_tag, stall} = '0;
    req_data = 64'h0;
    clk_en = 1'b1;
    repeat (16) @(negedge mclk);
    rstn = 1'b1;
    s_route();
    s_shape();
    s_freeze();
    end_sim();
  end
  // watchdog far past the few dozen cycles needed
  initial begin
    repeat (3000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
endmodule
bind tcr_router tcr_router_checker #(.ADDR_W(ADDR_W), .LEN_W(LEN_W)) tcr_router_checker_i (
  .mclk, .rstn, .clk_en, .req_valid, .req_ready, .req_from_cpu, .req_lock, .link_valid,
  .link_ready, .abort_valid, .link_cyc, .req_len, .link_len, .req_addr, .link_addr);
